/* File: inc/swc_defs.svh */
// Constants for the sleep, wake and clock fail control block.
// Assumes inclusion by bare name from the design and bench files.
`ifndef SWC_DEFS_SVH
`define SWC_DEFS_SVH
`define SWC_SRC_PRIMARY 2'h0
`define SWC_SRC_FAILSAFE 2'h2
`define SWC_FCM_DIV 64
`define SWC_OST_CYCLES 1024
`define SWC_IRQ_VECTOR 13'h0004
`define SWC_ADDR_CTRL 4'h0
`define SWC_ADDR_STATUS 4'h1
`define SWC_ADDR_IRQEN 4'h2
`define SWC_ADDR_IRQFL 4'h3
`define SWC_ADDR_OSC 4'h4
`define SWC_ADDR_PORT 4'h5
`define SWC_NUM_IRQ 12
`define SWC_BIT_PD 0
`define SWC_BIT_TO 1
`define SWC_BIT_PRIMARY_CLOCK_RUNNING_FLAG 2
`define SWC_BIT_OSF 3
`define SWC_BIT_FS 4
`define SWC_BIT_SLEEP 5
`define SWC_CTRL_WDT_EN 0
`define SWC_CTRL_GIE 1
`endif

/* File: inc/swc_pkg.sv */
// Types shared by the sleep and wake control files.
// Assumes swc_defs.svh is on the include path.
package swc_pkg;
  // Primary oscillator modes
  typedef enum logic [2:0] {
    SWC_MODE_EXT_CLK = 3'h0,
    SWC_MODE_RC = 3'h1,
    SWC_MODE_SLOW_INT = 3'h2,
    SWC_MODE_LP_XTAL = 3'h3,
    SWC_MODE_STD_XTAL = 3'h4,
    SWC_MODE_HS_XTAL = 3'h5
  } swc_osc_mode_t;
  // Power states, Gray along run, sleep, wake
  typedef enum logic [1:0] {
    SWC_ST_RUN = 2'h0,
    SWC_ST_SLEEP = 2'h1,
    SWC_ST_WAKE = 2'h3
  } swc_state_t;
  typedef struct packed {
    logic master_clear;
    logic wdt_expire;
    logic ext_pin;
    logic port_change;
  } swc_wake_src_t;
  // Core to block instruction strobes
  typedef struct packed {
    logic sleep_instr;
    logic wdt_clear_instr;
  } swc_core_req_t;
endpackage : swc_pkg

/* File: design/swc_fail_monitor.sv */
// Clock fail monitor: slow oscillator divide, latch and check.
// Assumes the slow oscillator and system clock edges are synchronous pulses.
`timescale 1ns/10ps
`include "swc_defs.svh"
module swc_fail_monitor import swc_pkg::*; #(
  parameter int DIV = `SWC_FCM_DIV
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Control
  input wire logic enable_i,
  input wire logic slow_tick_i,
  input wire logic sys_fall_i,
  // Result
  output logic fail_o
);
  initial begin
    if (DIV < 2) $error("DIV must be at least 2");
  end
  localparam int W = $clog2(DIV);
  logic [W-1:0] div_cnt;
  logic latch_set;
  logic sample_rise;
  logic sample_fall;
  wire [W-1:0] half = W'(DIV / 2);
  wire [W-1:0] last = W'(DIV - 1);
  // Sample clock: slow oscillator divided by DIV
  assign sample_rise = slow_tick_i && div_cnt == last;
  assign sample_fall = slow_tick_i && div_cnt == half - W'(1);
  assign fail_o = enable_i && sample_fall && !latch_set && !sys_fall_i;
  always_ff @(posedge clk_i) begin
    if (reset_i || !enable_i) begin
      div_cnt <= '0;
    end else if (slow_tick_i) begin
      div_cnt <= (div_cnt == last) ? '0 : div_cnt + W'(1);
    end
  end
  // Set wins over clear so a same-cycle edge is kept
  always_ff @(posedge clk_i) begin
    if (reset_i || !enable_i) begin
      latch_set <= 1'b1;
    end else if (sys_fall_i) begin
      latch_set <= 1'b1;
    end else if (sample_rise) begin
      latch_set <= 1'b0;
    end
  end
  a_latch_clear_rise: assert property (@(posedge clk_i) disable iff (reset_i)
    enable_i && sample_rise && !sys_fall_i |=> !latch_set)
    else $error("latch not cleared by sample rise");
endmodule : swc_fail_monitor

/* File: design/swc_sleep_ctrl.sv */
// Sleep entry, wake-up and fail-safe clock control.
// Assumes slow_tick_i, sys_fall_i, primary_tick_i are clk_i-domain pulses;
// pins and wake sources are asynchronous and synchronised here.
//
// What this block does
// - Clock failure forces clock source field to 10, resetting enabled watchdog.
// - Non-crystal primary modes start monitoring right after reset or wake.
// - Crystal modes run internally until start-up timer ends, then monitor.
// - Crystal failing during start-up timer is not flagged.
// - Sleep ends fail-safe; next wake retries crystal without new flag.
// - Software clock source change clears fail-safe and releases watchdog counter.
// - Sleep clears watchdog, clears power-down, sets expiry flag, stops driver.
// - Ports hold their drive state during sleep.
// - Wake on master clear, watchdog, pin, port change, peripheral interrupt.
// - Master clear in sleep resets; others resume execution.
// - Power-down set at power-up; expiry cleared on watchdog wake.
// - Only listed peripheral interrupts can wake the device.
// - Clocked peripherals raise no interrupts in sleep.
// - Sleep instruction prefetches next program counter location.
// - Enabled source wakes regardless of global enable.
// - After wake run next instruction, then vector if global enable.
// - Pending enabled interrupt makes sleep a no-operation.
// - Interrupt during or after sleep completes sleep then wakes.
// - Monitor sample clock is slow oscillator divided by 64.
// - Failure raises fail interrupt and switches to internal oscillator.
// - Start-up timer counts 1024 primary cycles before stable.
// - Latch cleared on sample rise, set on system fall; fail if still clear.
`timescale 1ns/10ps
`include "swc_defs.svh"
module swc_sleep_ctrl import swc_pkg::*; #(
  parameter int NUM_IRQ = `SWC_NUM_IRQ,
  parameter int OST_CYCLES = `SWC_OST_CYCLES,
  parameter int PC_W = 13,
  parameter int PORT_W = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [15:0] reg_rdata_o,
  // Core
  input wire swc_core_req_t core_req_i,
  input wire logic [PC_W-1:0] pc_i,
  output logic [PC_W-1:0] prefetch_pc_o,
  output logic prefetch_o,
  output logic core_halt_o,
  output logic resume_o,
  output logic vector_o,
  output logic [PC_W-1:0] vector_pc_o,
  output logic device_reset_o,
  // Wake sources, asynchronous
  input wire swc_wake_src_t wake_src_i,
  input wire logic [NUM_IRQ-1:0] periph_irq_i,
  input wire logic [NUM_IRQ-1:0] sleep_capable_i,
  // Oscillator
  input wire swc_osc_mode_t osc_mode_i,
  input wire logic fcm_enable_i,
  input wire logic slow_tick_i,
  input wire logic sys_fall_i,
  input wire logic primary_tick_i,
  output logic [1:0] clock_source_bits_o,
  output logic osc_driver_on_o,
  output logic use_internal_osc_o,
  output logic watchdog_reset_o,
  output logic watchdog_counter_release_o,
  output logic osc_fail_irq_o,
  // Ports
  input wire logic [PORT_W-1:0] port_drive_i,
  input wire logic [PORT_W-1:0] port_oe_n_i,
  output logic [PORT_W-1:0] port_drive_o,
  output logic [PORT_W-1:0] port_oe_n_o
);
  initial begin
    if (NUM_IRQ < 1 || NUM_IRQ > 16) $error("NUM_IRQ must be 1..16");
    if (OST_CYCLES < 2) $error("OST_CYCLES must be at least 2");
  end
  localparam int OW = $clog2(OST_CYCLES + 1);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [3:0] src_s1, src_s2;
  logic [NUM_IRQ-1:0] irq_s1, irq_s2;
  always_ff @(posedge clk_i) begin
    src_s1 <= wake_src_i;
    src_s2 <= src_s1;
    irq_s1 <= periph_irq_i;
    irq_s2 <= irq_s1;
  end
  swc_wake_src_t src;
  assign src = swc_wake_src_t'(src_s2);

  // ----------------------------------------
  // State
  // ----------------------------------------
  swc_state_t state, next_state;
  logic power_down_flag, watchdog_expiry_flag;
  logic primary_clock_running_flag, osc_fail_flag, fail_safe;
  logic wdt_en, global_irq_enable;
  logic [NUM_IRQ-1:0] irq_en, irq_flag;
  logic [1:0] clock_source_bits;
  logic [OW-1:0] ost_cnt;
  logic [PORT_W-1:0] held_drive, held_oe_n;
  logic vector_pend;
  logic wake_reset_pend;

  function automatic logic is_crystal(input swc_osc_mode_t m);
    return m == SWC_MODE_LP_XTAL || m == SWC_MODE_STD_XTAL || m == SWC_MODE_HS_XTAL;
  endfunction : is_crystal

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire crystal = is_crystal(osc_mode_i);
  wire in_sleep = state == SWC_ST_SLEEP;
  wire wr_ctrl = reg_write_i && reg_addr_i == `SWC_ADDR_CTRL;
  wire wr_irqen = reg_write_i && reg_addr_i == `SWC_ADDR_IRQEN;
  wire wr_irqfl = reg_write_i && reg_addr_i == `SWC_ADDR_IRQFL;
  wire wr_osc = reg_write_i && reg_addr_i == `SWC_ADDR_OSC;
  wire src_change = wr_osc && reg_wdata_i[1:0] != clock_source_bits;
  // Clocked peripherals are masked out while asleep
  wire [NUM_IRQ-1:0] live_irq = in_sleep ? (irq_s2 & sleep_capable_i) : irq_s2;
  wire irq_pending = |(irq_flag & irq_en);
  wire wdt_wake = src.wdt_expire && wdt_en;
  wire wake_req = src.master_clear || wdt_wake || src.ext_pin || src.port_change
                  || irq_pending;
  wire sleep_exec = core_req_i.sleep_instr && state == SWC_ST_RUN && !irq_pending;
  wire ost_done = ost_cnt == OW'(OST_CYCLES);
  wire monitor_on = fcm_enable_i && state == SWC_ST_RUN && !fail_safe
                    && (!crystal || ost_done);
  logic fail_det;

  swc_fail_monitor #(
    .DIV(`SWC_FCM_DIV)
  ) u_monitor (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .enable_i(monitor_on),
    .slow_tick_i(slow_tick_i),
    .sys_fall_i(sys_fall_i),
    .fail_o(fail_det)
  );

  // ----------------------------------------
  // Power state machine
  // ----------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      SWC_ST_RUN: if (sleep_exec) next_state = SWC_ST_SLEEP;
      SWC_ST_SLEEP: if (wake_req) next_state = SWC_ST_WAKE;
      SWC_ST_WAKE: next_state = SWC_ST_RUN;
      default: next_state = SWC_ST_RUN;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (reset_i) state <= SWC_ST_RUN;
    else state <= next_state;
  end

  // ----------------------------------------
  // Flags
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      power_down_flag <= 1'b1;
      watchdog_expiry_flag <= 1'b1;
    end else if (sleep_exec) begin
      power_down_flag <= 1'b0;
      watchdog_expiry_flag <= 1'b1;
    end else if (in_sleep && wdt_wake) begin
      watchdog_expiry_flag <= 1'b0;
    end else if (core_req_i.wdt_clear_instr) begin
      power_down_flag <= 1'b1;
      watchdog_expiry_flag <= 1'b1;
    end
  end

  // Hardware set wins over software clear
  always_ff @(posedge clk_i) begin
    if (reset_i) irq_flag <= '0;
    else irq_flag <= (wr_irqfl ? (irq_flag & reg_wdata_i[NUM_IRQ-1:0]) : irq_flag) | live_irq;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wdt_en <= 1'b0;
      global_irq_enable <= 1'b0;
      irq_en <= '0;
    end else begin
      if (wr_ctrl) wdt_en <= reg_wdata_i[`SWC_CTRL_WDT_EN];
      if (wr_ctrl) global_irq_enable <= reg_wdata_i[`SWC_CTRL_GIE];
      if (wr_irqen) irq_en <= reg_wdata_i[NUM_IRQ-1:0];
    end
  end

  // ----------------------------------------
  // Clock source and fail-safe
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      clock_source_bits <= `SWC_SRC_PRIMARY;
      fail_safe <= 1'b0;
      osc_fail_flag <= 1'b0;
    end else begin
      if (fail_det) begin
        clock_source_bits <= `SWC_SRC_FAILSAFE;
        fail_safe <= 1'b1;
      end else begin
        // Sleep and a source change may land together; either ends fail-safe
        if (wr_osc) clock_source_bits <= reg_wdata_i[1:0];
        if (src_change) fail_safe <= 1'b0;
        if (sleep_exec) fail_safe <= 1'b0;
      end
      if (fail_det) osc_fail_flag <= 1'b1;
      else if (wr_osc && reg_wdata_i[`SWC_BIT_OSF]) osc_fail_flag <= 1'b0;
    end
  end

  // Start-up timer restarts on each wake; sleep aborts it
  always_ff @(posedge clk_i) begin
    if (reset_i || state != SWC_ST_RUN || !crystal) ost_cnt <= '0;
    else if (primary_tick_i && !ost_done) ost_cnt <= ost_cnt + OW'(1);
  end
  assign primary_clock_running_flag = crystal ? ost_done : 1'b1;

  // ----------------------------------------
  // Core sequencing and ports
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      prefetch_o <= 1'b0;
      prefetch_pc_o <= '0;
      vector_pend <= 1'b0;
      wake_reset_pend <= 1'b0;
      held_drive <= '0;
      held_oe_n <= '1;
    end else begin
      prefetch_o <= core_req_i.sleep_instr;
      if (core_req_i.sleep_instr) prefetch_pc_o <= pc_i + PC_W'(1);
      if (sleep_exec) begin
        held_drive <= port_drive_i;
        held_oe_n <= port_oe_n_i;
      end
      wake_reset_pend <= in_sleep && wake_req && src.master_clear;
      vector_pend <= in_sleep && wake_req && !src.master_clear && irq_pending
                     && global_irq_enable;
    end
  end
  assign core_halt_o = state != SWC_ST_RUN;
  assign device_reset_o = wake_reset_pend;
  assign resume_o = state == SWC_ST_WAKE && !wake_reset_pend;
  assign vector_o = vector_pend && state == SWC_ST_WAKE;
  assign vector_pc_o = PC_W'(`SWC_IRQ_VECTOR);
  assign port_drive_o = in_sleep ? held_drive : port_drive_i;
  assign port_oe_n_o = in_sleep ? held_oe_n : port_oe_n_i;
  assign clock_source_bits_o = clock_source_bits;
  assign osc_driver_on_o = !in_sleep;
  assign use_internal_osc_o = fail_safe || (crystal && !ost_done);
  // Every watchdog clear source merges into one pulse
  assign watchdog_reset_o = sleep_exec || (fail_det && wdt_en)
                            || core_req_i.wdt_clear_instr;
  assign watchdog_counter_release_o = src_change;
  assign osc_fail_irq_o = osc_fail_flag;

  // ----------------------------------------
  // Register read
  // ----------------------------------------
  logic [15:0] status_word, rd_mux;
  always_comb begin
    status_word = '0;
    status_word[`SWC_BIT_PD] = power_down_flag;
    status_word[`SWC_BIT_TO] = watchdog_expiry_flag;
    status_word[`SWC_BIT_PRIMARY_CLOCK_RUNNING_FLAG] = primary_clock_running_flag;
    status_word[`SWC_BIT_OSF] = osc_fail_flag;
    status_word[`SWC_BIT_FS] = fail_safe;
    status_word[`SWC_BIT_SLEEP] = in_sleep;
    rd_mux = '0;
    unique case (reg_addr_i)
      `SWC_ADDR_CTRL: rd_mux = {14'h0000, global_irq_enable, wdt_en};
      `SWC_ADDR_STATUS: rd_mux = status_word;
      `SWC_ADDR_IRQEN: rd_mux[NUM_IRQ-1:0] = irq_en;
      `SWC_ADDR_IRQFL: rd_mux[NUM_IRQ-1:0] = irq_flag;
      `SWC_ADDR_OSC: rd_mux[1:0] = clock_source_bits;
      default: rd_mux = '0;
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (reset_i) reg_rdata_o <= '0;
    else if (reg_read_i) reg_rdata_o <= rd_mux;
    else reg_rdata_o <= '0;
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_fail_forces_src: assert property (@(posedge clk_i) disable iff (reset_i)
    fail_det |=> clock_source_bits == `SWC_SRC_FAILSAFE && fail_safe)
    else $error("failure did not force source");
  a_sleep_flags: assert property (@(posedge clk_i) disable iff (reset_i)
    sleep_exec |=> !power_down_flag && watchdog_expiry_flag && !osc_driver_on_o)
    else $error("sleep flag update wrong");
  a_noop_sleep: assert property (@(posedge clk_i) disable iff (reset_i)
    core_req_i.sleep_instr && irq_pending && state == SWC_ST_RUN |=> state == SWC_ST_RUN
      && $stable(power_down_flag))
    else $error("pending irq sleep not a no-op");
  a_wake_one_cycle: assert property (@(posedge clk_i) disable iff (reset_i)
    in_sleep && wake_req |=> state == SWC_ST_WAKE ##1 state == SWC_ST_RUN)
    else $error("wake sequence wrong");
  a_no_monitor_ost: assert property (@(posedge clk_i) disable iff (reset_i)
    crystal && !ost_done && !osc_fail_flag |=> !osc_fail_flag)
    else $error("failure flagged during start-up");
  a_clear_resets: assert property (@(posedge clk_i) disable iff (reset_i)
    in_sleep && src.master_clear |=> device_reset_o && !resume_o)
    else $error("master clear wake did not reset");
  a_ports_held: assert property (@(posedge clk_i) disable iff (reset_i)
    in_sleep && $past(in_sleep) |-> $stable(port_drive_o) && $stable(port_oe_n_o))
    else $error("ports moved in sleep");
  a_sleep_ends_fs: assert property (@(posedge clk_i) disable iff (reset_i)
    sleep_exec && !fail_det |=> !fail_safe)
    else $error("sleep kept fail-safe");
  a_switch_clears_fs: assert property (@(posedge clk_i) disable iff (reset_i)
    src_change && !fail_det |=> !fail_safe)
    else $error("clock switch kept fail-safe");
  a_wdt_wake_flag: assert property (@(posedge clk_i) disable iff (reset_i)
    in_sleep && wdt_wake && !sleep_exec |=> !watchdog_expiry_flag)
    else $error("expiry flag not cleared");
endmodule : swc_sleep_ctrl

/* File: tb/swc_osc_model.sv */
// Oscillator side model: slow oscillator, system clock and crystal edges.
// Assumes the bench starts and stops the system clock and crystal through the run inputs.
`timescale 1ns/10ps
module swc_osc_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Bench control
  input wire logic sys_run_i,
  input wire logic xtal_run_i,
  // Edge pulses
  output logic slow_tick_o,
  output logic sys_fall_o,
  output logic primary_tick_o
);
  logic [1:0] phase;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  // Slow edge every fourth cycle; the monitor divides it further
  assign slow_tick_o = (phase == 2'h3);
  // A dead clock just stops its edges, nothing else marks the failure
  assign sys_fall_o = sys_run_i & phase[0];
  assign primary_tick_o = xtal_run_i & ~phase[0];
endmodule : swc_osc_model

/* File: tb/swc_sleep_ctrl_tb.sv */
// Self-checking bench for the sleep, wake and clock fail control block.
// Assumes swc_defs.svh on the include path and an 8-cycle start-up timer.
`timescale 1ns/10ps
`include "swc_defs.svh"
module swc_sleep_ctrl_tb import swc_pkg::*;;
  logic clk_i, reset_i, reg_write_i, reg_read_i, fcm_enable_i, sys_run, xtal_run;
  logic [3:0] reg_addr_i;
  logic [15:0] reg_wdata_i, reg_rdata_o, d;
  logic [15:0] port_drive_i, port_oe_n_i, port_drive_o, port_oe_n_o;
  logic [12:0] pc_i, prefetch_pc_o, vector_pc_o;
  logic [11:0] periph_irq_i, sleep_capable_i;
  logic [1:0] clock_source_bits_o;
  logic core_halt_o, resume_o, vector_o, device_reset_o, prefetch_o;
  logic slow_tick, sys_fall, primary_tick, osc_driver_on_o, use_internal_osc_o;
  logic watchdog_reset_o, watchdog_counter_release_o, osc_fail_irq_o;
  swc_core_req_t core_req_i;
  swc_wake_src_t wake_src_i;
  swc_osc_mode_t osc_mode_i;
  int failures, n_checks, cycles, g, e, w;
  int ev[5];

  swc_sleep_ctrl #(.OST_CYCLES(8)) u_dut (.clk_i(clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o),
    .core_req_i(core_req_i), .pc_i(pc_i), .prefetch_pc_o(prefetch_pc_o), .prefetch_o(prefetch_o),
    .core_halt_o(core_halt_o), .resume_o(resume_o), .vector_o(vector_o), .vector_pc_o(vector_pc_o),
    .device_reset_o(device_reset_o), .wake_src_i(wake_src_i), .periph_irq_i(periph_irq_i),
    .sleep_capable_i(sleep_capable_i), .osc_mode_i(osc_mode_i), .fcm_enable_i(fcm_enable_i),
    .slow_tick_i(slow_tick), .sys_fall_i(sys_fall), .primary_tick_i(primary_tick),
    .clock_source_bits_o(clock_source_bits_o), .osc_driver_on_o(osc_driver_on_o),
    .use_internal_osc_o(use_internal_osc_o), .watchdog_reset_o(watchdog_reset_o),
    .watchdog_counter_release_o(watchdog_counter_release_o), .osc_fail_irq_o(osc_fail_irq_o),
    .port_drive_i(port_drive_i), .port_oe_n_i(port_oe_n_i), .port_drive_o(port_drive_o),
    .port_oe_n_o(port_oe_n_o));

  swc_osc_model u_osc (.clk_i(clk_i), .reset_i(reset_i), .sys_run_i(sys_run), .xtal_run_i(xtal_run),
    .slow_tick_o(slow_tick), .sys_fall_o(sys_fall), .primary_tick_o(primary_tick));

  always #2 clk_i = ~clk_i;

  // -----------------------------------------------------------------
  // Pulse counters and hang guard
  // -----------------------------------------------------------------
  // Counting pulses avoids guessing the exact cycle of each comb pulse
  always @(posedge clk_i) begin
    if (resume_o === 1'b1) ev[0]++;
    if (vector_o === 1'b1) ev[1]++;
    if (device_reset_o === 1'b1) ev[2]++;
    if (watchdog_reset_o === 1'b1) ev[3]++;
    if (watchdog_counter_release_o === 1'b1) ev[4]++;
    cycles++;
    if (cycles == 20000) begin
      failures++;
      give_verdict();
    end
  end

  // -----------------------------------------------------------------
  // Tasks
  // -----------------------------------------------------------------
  task automatic give_verdict();
    if (failures == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic reg_wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_i);
    reg_write_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge clk_i);
    reg_write_i <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk_i);
    reg_read_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_read_i <= 1'b0;
    @(negedge clk_i);
    v = reg_rdata_o;
  endtask : reg_rd

  task automatic wait_ev(input int k);
    int s;
    s = ev[k];
    for (int i = 0; i < 20 && ev[k] == s; i++) @(negedge clk_i);
    chk("wake event", 16'h1, 16'(ev[k] != s));
    @(posedge clk_i);
  endtask : wait_ev

  task automatic wait_fail();
    @(posedge clk_i);
    sys_run <= 1'b0;
    for (int i = 0; i < 1000 && clock_source_bits_o !== 2'h2; i++) @(negedge clk_i);
  endtask : wait_fail

  task automatic do_reset();
    @(posedge clk_i);
    reset_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    reset_i <= 1'b0;
  endtask : do_reset

  task automatic sleep_chk(input logic [12:0] pc, input logic ex);
    int s;
    logic [15:0] st;
    s = ev[3];
    @(posedge clk_i);
    core_req_i.sleep_instr <= 1'b1;
    pc_i <= pc;
    @(posedge clk_i);
    core_req_i.sleep_instr <= 1'b0;
    @(negedge clk_i);
    chk("halt", 16'(ex), 16'(core_halt_o));
    chk("watchdog clear", 16'(ex), 16'(ev[3] != s));
    if (ex) begin
      chk("prefetch", 16'h1, 16'(prefetch_o));
      chk("prefetch pc", 16'(pc + 13'h1), 16'(prefetch_pc_o));
      chk("driver", 16'h0, 16'(osc_driver_on_o));
    end
    reg_rd(`SWC_ADDR_STATUS, st);
    chk("status", ex ? 16'h0022 : 16'h0003, st & 16'h0023);
    @(posedge clk_i);
  endtask : sleep_chk

  // -----------------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------------
  initial begin
    clk_i = 1'b0; reset_i = 1'b1; reg_write_i = 1'b0; reg_read_i = 1'b0; reg_addr_i = 4'h0;
    reg_wdata_i = 16'h0; core_req_i = '0; pc_i = 13'h0; wake_src_i = '0; periph_irq_i = 12'h0;
    sleep_capable_i = 12'h005; osc_mode_i = SWC_MODE_EXT_CLK; fcm_enable_i = 1'b1;
    port_drive_i = 16'h00a5; port_oe_n_i = 16'h00f0; sys_run = 1'b1; xtal_run = 1'b0;
    do_reset();
    reg_rd(`SWC_ADDR_STATUS, d);
    chk("status at reset", 16'h0003, d & 16'h003b);
    reg_rd(4'hf, d);
    chk("unmapped", 16'h0, d);
    reg_wr(`SWC_ADDR_IRQEN, 16'h0003);
    for (g = 0; g < 2; g++) begin
      reg_wr(`SWC_ADDR_CTRL, {14'h0, g[0], 1'b1});
      sleep_chk(13'h0100, 1'b1);
      if (g == 0) begin
        @(posedge clk_i);
        port_drive_i <= 16'h5a00;
        port_oe_n_i <= 16'h0f00;
        periph_irq_i <= 12'h006;
        repeat (20) @(negedge clk_i);
        chk("halt", 16'h1, 16'(core_halt_o));
        chk("port drive", 16'h00a5, port_drive_o);
        chk("port oe", 16'h00f0, port_oe_n_o);
        @(posedge clk_i);
        periph_irq_i <= 12'h000;
        @(posedge clk_i);
      end
      e = ev[1];
      periph_irq_i[0] <= 1'b1;
      wait_ev(0);
      chk("vector", 16'(g), 16'(ev[1] - e));
      chk("vector pc", 16'h0004, 16'(vector_pc_o));
      periph_irq_i[0] <= 1'b0;
      repeat (4) @(posedge clk_i);
      reg_wr(`SWC_ADDR_IRQFL, 16'h0);
    end
    chk("port after wake", 16'h5a00, port_drive_o);
    for (g = 0; g < 2; g++) begin
      sleep_chk(13'h0180, 1'b1);
      if (g == 0) wake_src_i.ext_pin <= 1'b1;
      else wake_src_i.port_change <= 1'b1;
      wait_ev(0);
      wake_src_i <= '0;
    end
    sleep_chk(13'h0200, 1'b1);
    wake_src_i.wdt_expire <= 1'b1;
    wait_ev(0);
    wake_src_i.wdt_expire <= 1'b0;
    reg_rd(`SWC_ADDR_STATUS, d);
    chk("expiry flag", 16'h0, d & 16'h0003);
    @(posedge clk_i);
    core_req_i.wdt_clear_instr <= 1'b1;
    @(posedge clk_i);
    core_req_i.wdt_clear_instr <= 1'b0;
    periph_irq_i[0] <= 1'b1;
    repeat (4) @(posedge clk_i);
    sleep_chk(13'h0300, 1'b0);
    @(posedge clk_i);
    periph_irq_i[0] <= 1'b0;
    repeat (4) @(posedge clk_i);
    reg_wr(`SWC_ADDR_IRQFL, 16'h0);
    sleep_chk(13'h0400, 1'b1);
    e = ev[0];
    wake_src_i.master_clear <= 1'b1;
    wait_ev(2);
    chk("resume on clear", 16'h0, 16'(ev[0] - e));
    wake_src_i.master_clear <= 1'b0;
    do_reset();
    reg_wr(`SWC_ADDR_CTRL, 16'h0001);
    w = ev[3];
    wait_fail();
    chk("source", 16'h2, 16'(clock_source_bits_o));
    chk("watchdog reset", 16'h1, 16'(ev[3] != w));
    chk("fail irq", 16'h1, 16'(osc_fail_irq_o));
    chk("internal osc", 16'h1, 16'(use_internal_osc_o));
    reg_rd(`SWC_ADDR_STATUS, d);
    chk("fail flags", 16'h0018, d & 16'h0018);
    @(posedge clk_i);
    sys_run <= 1'b1;
    w = ev[4];
    reg_wr(`SWC_ADDR_OSC, 16'h0008);
    reg_rd(`SWC_ADDR_STATUS, d);
    chk("fail flags", 16'h0, d & 16'h0018);
    chk("counter release", 16'h1, 16'(ev[4] != w));
    wait_fail();
    sleep_chk(13'h0500, 1'b1);
    reg_rd(`SWC_ADDR_STATUS, d);
    chk("failsafe", 16'h0, d & 16'h0010);
    @(posedge clk_i);
    osc_mode_i <= SWC_MODE_STD_XTAL;
    do_reset();
    repeat (600) @(posedge clk_i);
    reg_rd(`SWC_ADDR_STATUS, d);
    chk("dead crystal", 16'h0, d & 16'h001c);
    chk("internal osc", 16'h1, 16'(use_internal_osc_o));
    @(posedge clk_i);
    xtal_run <= 1'b1;
    sys_run <= 1'b1;
    repeat (100) @(posedge clk_i);
    reg_rd(`SWC_ADDR_STATUS, d);
    chk("crystal up", 16'h0004, d & 16'h001c);
    chk("internal osc", 16'h0, 16'(use_internal_osc_o));
    give_verdict();
  end
endmodule : swc_sleep_ctrl_tb
